// file: common/timer16_map.vh
// Purpose: register offsets, field positions, reset values and mode codes of the timer
// Assumes: included by the timer design files
// Notes: definitions only
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// register byte offsets on the APB bus
`define OFF_CTRL_A 12'h000
`define OFF_CTRL_B 12'h004
`define OFF_COUNT 12'h008
`define OFF_MATCH_A 12'h00C
`define OFF_MATCH_B 12'h010
`define OFF_CAPTURE 12'h014
`define OFF_STATUS 12'h018
// timer_control_a fields
`define CA_ACT_A_HI 7
`define CA_ACT_A_LO 6
`define CA_ACT_B_HI 5
`define CA_ACT_B_LO 4
`define CA_FORCE_A 3
`define CA_FORCE_B 2
`define CA_WAVE_HI 1
`define CA_WAVE_LO 0
`define CA_RW_MASK 8'hF3
// timer_control_b fields
`define CB_WAVE_HI 4
`define CB_WAVE_LO 3
`define CB_RUN 0
`define CB_RW_MASK 8'h19
`define CTRL_RESET 8'h00
// status bits
`define ST_WRAP 0
`define ST_MATCH_A 1
`define ST_MATCH_B 2
`define ST_DOWN 3
`define ST_PIN_A 4
`define ST_PIN_B 5
// waveform modes
`define WM_NORMAL 4'h0
`define WM_PC8 4'h1
`define WM_PC9 4'h2
`define WM_PC10 4'h3
`define WM_CTC_A 4'h4
`define WM_FP8 4'h5
`define WM_FP9 4'h6
`define WM_FP10 4'h7
`define WM_PFC_CAP 4'h8
`define WM_PFC_A 4'h9
`define WM_PC_CAP 4'hA
`define WM_PC_A 4'hB
`define WM_CTC_CAP 4'hC
`define WM_RESERVED 4'hD
`define WM_FP_CAP 4'hE
`define WM_FP_A 4'hF
// fixed tops
`define TOP_MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define BOTTOM 16'h0000
// output action codes
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3
`endif

// file: core/compare_output.v
// Purpose: one channel's compare pin, acting on match, bottom or force events
// Assumes: events are one-cycle pulses on mclk
// Notes: pin enable is combinational from the action bits and mode class
`timescale 1ns/100ps
`include "timer16_map.vh"
module compare_output
(
   mclk,
   reset,
   action,
   allow_toggle,
   pwm_fast,
   pwm_dual,
   reserved_mode,
   count_down,
   match_hit,
   bottom_hit,
   top_equal,
   force_hit,
   pin_q,
   pin_drive
);
   input wire mclk;
   input wire reset;
   input wire [1:0] action;
   input wire allow_toggle;
   input wire pwm_fast;
   input wire pwm_dual;
   input wire reserved_mode;
   input wire count_down;
   input wire match_hit;
   input wire bottom_hit;
   input wire top_equal;
   input wire force_hit;
   output reg pin_q;
   output wire pin_drive;

   reg pin_d;
   wire toggle_ok;

   // toggle code only lives in non-pwm modes or the allowed pwm modes
   assign toggle_ok = !(pwm_fast || pwm_dual) || allow_toggle; // RQ2
   // any nonzero action overrides the port outside the reserved mode, except where the code means disconnected
   assign pin_drive = !reserved_mode && (action != `ACT_OFF) && // RQ1 RQ19 RQ20
      !(action == `ACT_TOGGLE && !toggle_ok);

   always @*
   begin
      pin_d = pin_q;
      if (pin_drive)
      begin
         if (pwm_fast && action[1])
         begin
            // compare equal to top: match ignored, action done at bottom instead
            if (match_hit && !top_equal)
               pin_d = (action == `ACT_SET);
            if (bottom_hit)
               pin_d = (action == `ACT_CLEAR); // RQ5
         end
         else if (pwm_dual && action[1])
         begin
            if (match_hit)
               pin_d = count_down ? (action == `ACT_CLEAR) : (action == `ACT_SET); // RQ3 RQ4
         end
         else if (match_hit || force_hit) // RQ8 RQ9
         begin
            case (action)
               `ACT_TOGGLE: pin_d = ~pin_q;
               `ACT_CLEAR: pin_d = 1'b0;
               `ACT_SET: pin_d = 1'b1;
               default: pin_d = pin_q;
            endcase
         end
      end
   end

   always @(posedge mclk)
   begin
      if (reset)
         pin_q <= 1'b0;
      else
         pin_q <= pin_d;
   end
endmodule

// file: core/timer16_wave.v
// Purpose: 16-bit timer with waveform modes, double-buffered compares and two compare pins
// Assumes: APB slave, mclk 100 MHz, synchronous active-high reset, tick_en is the timer enable
// Notes: the capture register is written by software only; capture input lies outside
//
// Overview of operation
// (RQ1) pwm modes, action 00: pin disconnected
// (RQ2) action 01 toggles A only in 9/14
// (RQ3) action 10: clear up, set down
// (RQ4) action 11: set up, clear down
// (RQ5) fast pwm, compare equals top: act at bottom
// (RQ6) force strobes work only in non-pwm modes
// (RQ7) software writes force zero in pwm modes
// (RQ8) force strobe makes an immediate compare match
// (RQ9) forced action uses current action bits
// (RQ10) force sets no flag, clears no counter
// (RQ11) force bits always read zero
// (RQ12) low mode bits 1:0, high in control b
// (RQ13) 4-bit mode picks sequence, top, waveform
// (RQ14) modes 0,4,12: immediate update, wrap at max
// (RQ15) modes 1-3,10,11: update at top, wrap bottom
// (RQ16) mode 10 top capture, 11 top compare a
// (RQ17) fast pwm: update bottom, wrap at top
// (RQ18) modes 8,9: update and wrap at bottom
// (RQ19) nonzero action bits override port function
// (RQ20) reserved mode 13 stops, pins disconnected
`timescale 1ns/100ps
`include "timer16_map.vh"
module timer16_wave
(
   mclk,
   reset,
   tick_en,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   compare_pin_a,
   compare_pin_b,
   pin_drive_a,
   pin_drive_b,
   wrap_flag,
   match_flag_a,
   match_flag_b
);
   input wire mclk;
   input wire reset;
   input wire tick_en;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [11:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   output reg compare_pin_a;
   output reg compare_pin_b;
   output reg pin_drive_a;
   output reg pin_drive_b;
   output reg wrap_flag;
   output reg match_flag_a;
   output reg match_flag_b;

   // ==========================================================
   // registers
   reg [7:0] timer_control_a_q;
   reg [7:0] timer_control_b_q;
   reg [15:0] count_value_q;
   reg [15:0] match_value_a_q;
   reg [15:0] match_value_b_q;
   reg [15:0] match_buf_a_q;
   reg [15:0] match_buf_b_q;
   reg [15:0] capture_value_q;
   reg down_q;
   reg [31:0] rdata_d;
   reg [15:0] top_d;
   reg is_fast;
   reg is_dual;
   reg upd_imm;
   reg upd_top;
   reg wrap_at_top;
   reg wrap_at_bottom;
   reg rd_ok;

   wire [3:0] wave_mode;
   wire [1:0] act_a;
   wire [1:0] act_b;
   wire setup_wr;
   wire access;
   wire reserved_mode;
   wire running;
   wire at_top;
   wire at_bottom;
   wire at_max;
   wire hit_a;
   wire hit_b;
   wire force_a;
   wire force_b;
   wire pin_a;
   wire pin_b;
   wire drive_a;
   wire drive_b;
   wire wr_count;

   assign wave_mode = {timer_control_b_q[`CB_WAVE_HI:`CB_WAVE_LO],
      timer_control_a_q[`CA_WAVE_HI:`CA_WAVE_LO]}; // RQ12
   assign act_a = timer_control_a_q[`CA_ACT_A_HI:`CA_ACT_A_LO];
   assign act_b = timer_control_a_q[`CA_ACT_B_HI:`CA_ACT_B_LO];
   assign reserved_mode = (wave_mode == `WM_RESERVED);
   assign running = tick_en && timer_control_b_q[`CB_RUN] && !reserved_mode; // RQ20

   // ==========================================================
   // mode decode
   always @*
   begin
      top_d = `TOP_MAX;
      is_fast = 1'b0;
      is_dual = 1'b0;
      upd_imm = 1'b0;
      upd_top = 1'b0;
      wrap_at_top = 1'b0;
      wrap_at_bottom = 1'b0;
      case (wave_mode) // RQ13
         `WM_NORMAL, `WM_CTC_A, `WM_CTC_CAP:
         begin
            upd_imm = 1'b1; // RQ14
            if (wave_mode == `WM_CTC_A)
               top_d = match_value_a_q;
            else if (wave_mode == `WM_CTC_CAP)
               top_d = capture_value_q;
         end
         `WM_PC8, `WM_PC9, `WM_PC10, `WM_PC_CAP, `WM_PC_A:
         begin
            is_dual = 1'b1; // RQ15
            upd_top = 1'b1;
            wrap_at_bottom = 1'b1;
            case (wave_mode)
               `WM_PC8: top_d = `TOP_8;
               `WM_PC9: top_d = `TOP_9;
               `WM_PC10: top_d = `TOP_10;
               `WM_PC_CAP: top_d = capture_value_q; // RQ16
               default: top_d = match_value_a_q;
            endcase
         end
         `WM_PFC_CAP, `WM_PFC_A:
         begin
            is_dual = 1'b1; // RQ18
            wrap_at_bottom = 1'b1;
            top_d = (wave_mode == `WM_PFC_CAP) ? capture_value_q : match_value_a_q;
         end
         `WM_FP8, `WM_FP9, `WM_FP10, `WM_FP_CAP, `WM_FP_A:
         begin
            is_fast = 1'b1; // RQ17
            wrap_at_top = 1'b1;
            case (wave_mode)
               `WM_FP8: top_d = `TOP_8;
               `WM_FP9: top_d = `TOP_9;
               `WM_FP10: top_d = `TOP_10;
               `WM_FP_CAP: top_d = capture_value_q;
               default: top_d = match_value_a_q;
            endcase
         end
         default: top_d = `TOP_MAX; // RQ20
      endcase
   end

   assign at_top = (count_value_q == top_d);
   assign at_bottom = (count_value_q == `BOTTOM);
   assign at_max = (count_value_q == `TOP_MAX);
   assign hit_a = running && (count_value_q == match_value_a_q);
   assign hit_b = running && (count_value_q == match_value_b_q);

   // ==========================================================
   // bus slave: one wait cycle before pready on each access
   assign access = psel && penable && !pready;
   assign setup_wr = access && pwrite;
   assign wr_count = setup_wr && (paddr == `OFF_COUNT);
   // force bits are strobes, never stored, and dropped in any pwm mode
   assign force_a = setup_wr && (paddr == `OFF_CTRL_A) && pwdata[`CA_FORCE_A]
      && !is_fast && !is_dual && !reserved_mode; // RQ6 RQ8
   assign force_b = setup_wr && (paddr == `OFF_CTRL_A) && pwdata[`CA_FORCE_B]
      && !is_fast && !is_dual && !reserved_mode; // RQ6 RQ8

   always @*
   begin
      rdata_d = 32'h00000000;
      rd_ok = 1'b1;
      case (paddr)
         `OFF_CTRL_A: rdata_d[7:0] = timer_control_a_q; // RQ11
         `OFF_CTRL_B: rdata_d[7:0] = timer_control_b_q;
         `OFF_COUNT: rdata_d[15:0] = count_value_q;
         `OFF_MATCH_A: rdata_d[15:0] = (upd_imm ? match_value_a_q : match_buf_a_q);
         `OFF_MATCH_B: rdata_d[15:0] = (upd_imm ? match_value_b_q : match_buf_b_q);
         `OFF_CAPTURE: rdata_d[15:0] = capture_value_q;
         `OFF_STATUS:
         begin
            rdata_d[`ST_WRAP] = wrap_flag;
            rdata_d[`ST_MATCH_A] = match_flag_a;
            rdata_d[`ST_MATCH_B] = match_flag_b;
            rdata_d[`ST_DOWN] = down_q;
            rdata_d[`ST_PIN_A] = compare_pin_a;
            rdata_d[`ST_PIN_B] = compare_pin_b;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge mclk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         timer_control_a_q <= `CTRL_RESET;
         timer_control_b_q <= `CTRL_RESET;
         capture_value_q <= `BOTTOM;
         match_buf_a_q <= `BOTTOM;
         match_buf_b_q <= `BOTTOM;
      end
      else
      begin
         pready <= access;
         pslverr <= access && !rd_ok;
         if (access && !pwrite)
            prdata <= rdata_d;
         if (setup_wr)
         begin
            case (paddr)
               `OFF_CTRL_A: timer_control_a_q <= pwdata[7:0] & `CA_RW_MASK; // RQ11
               `OFF_CTRL_B: timer_control_b_q <= pwdata[7:0] & `CB_RW_MASK;
               `OFF_MATCH_A: match_buf_a_q <= pwdata[15:0];
               `OFF_MATCH_B: match_buf_b_q <= pwdata[15:0];
               `OFF_CAPTURE: capture_value_q <= pwdata[15:0];
               default: prdata <= prdata;
            endcase
         end
      end
   end

   // ==========================================================
   // counter, compare buffers and flags (set wins over clear)
   always @(posedge mclk)
   begin
      if (reset)
      begin
         count_value_q <= `BOTTOM;
         down_q <= 1'b0;
         match_value_a_q <= `BOTTOM;
         match_value_b_q <= `BOTTOM;
         wrap_flag <= 1'b0;
         match_flag_a <= 1'b0;
         match_flag_b <= 1'b0;
      end
      else
      begin
         if (setup_wr && paddr == `OFF_STATUS)
         begin
            if (pwdata[`ST_WRAP])
               wrap_flag <= 1'b0;
            if (pwdata[`ST_MATCH_A])
               match_flag_a <= 1'b0;
            if (pwdata[`ST_MATCH_B])
               match_flag_b <= 1'b0;
         end
         // forced compares never reach the flags or the counter
         if (hit_a)
            match_flag_a <= 1'b1; // RQ10
         if (hit_b)
            match_flag_b <= 1'b1;
         if (upd_imm)
         begin
            match_value_a_q <= match_buf_a_q; // RQ14
            match_value_b_q <= match_buf_b_q;
         end
         if (wr_count)
            count_value_q <= pwdata[15:0];
         else if (running)
         begin
            if (is_dual)
            begin
               if (upd_top && at_top)
               begin
                  match_value_a_q <= match_buf_a_q; // RQ15
                  match_value_b_q <= match_buf_b_q;
               end
               if (!upd_top && at_bottom)
               begin
                  match_value_a_q <= match_buf_a_q; // RQ18
                  match_value_b_q <= match_buf_b_q;
               end
               if (at_bottom && down_q)
                  wrap_flag <= 1'b1; // RQ15 RQ18
               if (at_top)
               begin
                  down_q <= 1'b1;
                  count_value_q <= count_value_q - 16'h0001;
               end
               else if (at_bottom)
               begin
                  down_q <= 1'b0;
                  count_value_q <= count_value_q + 16'h0001;
               end
               else if (down_q)
                  count_value_q <= count_value_q - 16'h0001;
               else
                  count_value_q <= count_value_q + 16'h0001;
            end
            else
            begin
               down_q <= 1'b0;
               if (is_fast && at_bottom)
               begin
                  match_value_a_q <= match_buf_a_q; // RQ17
                  match_value_b_q <= match_buf_b_q;
               end
               if ((wrap_at_top && at_top) || (!wrap_at_top && at_max))
                  wrap_flag <= 1'b1; // RQ14 RQ17
               if (at_top)
                  count_value_q <= `BOTTOM;
               else
                  count_value_q <= count_value_q + 16'h0001;
            end
         end
      end
   end

   // ==========================================================
   // compare pins
   compare_output out_a
   (
      .mclk(mclk),
      .reset(reset),
      .action(act_a),
      .allow_toggle(wave_mode == `WM_PFC_A || wave_mode == `WM_FP_CAP), // RQ2
      .pwm_fast(is_fast),
      .pwm_dual(is_dual),
      .reserved_mode(reserved_mode),
      .count_down(down_q),
      .match_hit(hit_a),
      .bottom_hit(running && is_fast && at_top),
      .top_equal(match_value_a_q == top_d),
      .force_hit(force_a),
      .pin_q(pin_a),
      .pin_drive(drive_a)
   );

   compare_output out_b
   (
      .mclk(mclk),
      .reset(reset),
      .action(act_b),
      .allow_toggle(1'b0),
      .pwm_fast(is_fast),
      .pwm_dual(is_dual),
      .reserved_mode(reserved_mode),
      .count_down(down_q),
      .match_hit(hit_b),
      .bottom_hit(running && is_fast && at_top),
      .top_equal(match_value_b_q == top_d),
      .force_hit(force_b),
      .pin_q(pin_b),
      .pin_drive(drive_b)
   );

   always @(posedge mclk)
   begin
      if (reset)
      begin
         compare_pin_a <= 1'b0;
         compare_pin_b <= 1'b0;
         pin_drive_a <= 1'b0;
         pin_drive_b <= 1'b0;
      end
      else
      begin
         compare_pin_a <= pin_a;
         compare_pin_b <= pin_b;
         pin_drive_a <= drive_a; // RQ19
         pin_drive_b <= drive_b;
      end
   end
endmodule

// file: verification/port_pin_model.sv
// Purpose: port logic that a compare pin feeds on its way to the pad
// Assumes: dir_out high enables the pad driver
// Notes: an undriven pad floats to its pull-up
`timescale 1ns/100ps
module port_pin_model
(
   input wire compare_pin,
   input wire pin_drive,
   input wire port_out,
   input wire dir_out,
   output wire pad
);
   assign pad = !dir_out ? 1'b1 : (pin_drive ? compare_pin : port_out);
endmodule

// file: verification/timer16_wave_properties.sv
// Purpose: concurrent checks on bus handshake, pin enables and forced compares
// Assumes: one clock domain, synchronous active-high reset
// Notes: shadows both control registers from taken bus writes
`timescale 1ns/100ps
`include "timer16_map.vh"
module timer16_wave_properties
(
   input wire mclk,
   input wire reset,
   input wire tick_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire compare_pin_a,
   input wire compare_pin_b,
   input wire pin_drive_a,
   input wire pin_drive_b,
   input wire wrap_flag,
   input wire match_flag_a,
   input wire match_flag_b
);
   // ==========================================================
   // shadow of the mode and action bits
   reg [7:0] ctrl_a_q;
   reg [7:0] ctrl_b_q;
   wire taken_wr = psel && penable && !pready && pwrite;
   wire [3:0] mode = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
   wire pwm = !(mode == `WM_NORMAL || mode == `WM_CTC_A || mode == `WM_CTC_CAP);
   always @(posedge mclk)
   begin
      if (reset)
      begin
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= 8'h00;
      end
      else if (taken_wr && paddr == `OFF_CTRL_A)
         ctrl_a_q <= pwdata[7:0];
      else if (taken_wr && paddr == `OFF_CTRL_B)
         ctrl_b_q <= pwdata[7:0];
   end
   // ==========================================================
   // properties
   default clocking dclk @(posedge mclk);
   endclocking
   default disable iff (reset);
   // stopped timer, so only the strobe can move the pin; it acts with the bits held before
   sequence s_force_a(logic [1:0] act);
      taken_wr && paddr == `OFF_CTRL_A && pwdata[3] && ctrl_a_q[7:6] == act && !pwm
         && !tick_en;
   endsequence
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no ready one cycle after the access edge");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_error_unmapped: assert property (pready && psel && paddr > `OFF_STATUS |-> pslverr)
      else $error("unmapped access without error");
   a_force_reads_zero: assert property (pready && psel && !pwrite && paddr == `OFF_CTRL_A
      |-> prdata[3:2] == 2'b00)
      else $error("force bits read back nonzero");
   a_idle_no_drive: assert property (ctrl_a_q[7:6] == 2'b00 [*3] |-> !pin_drive_a)
      else $error("pin a driven with zero action bits");
   a_reserved_released: assert property (mode == `WM_RESERVED [*3]
      |-> !pin_drive_a && !pin_drive_b)
      else $error("pins driven in reserved mode");
   a_toggle_b_off: assert property (ctrl_a_q[5:4] == 2'b01 && pwm [*3] |-> !pin_drive_b)
      else $error("pin b driven by toggle code in pulse mode");
   a_drive_on_action: assert property (ctrl_a_q[7] && mode != `WM_RESERVED [*3]
      |-> pin_drive_a)
      else $error("pin a not driven with upper action bit set");
   a_force_sets_pin: assert property (s_force_a(2'b11) |-> ##[1:3] compare_pin_a)
      else $error("forced set did not raise pin a");
   a_force_clears_pin: assert property (s_force_a(2'b10) |-> ##[1:3] !compare_pin_a)
      else $error("forced clear did not lower pin a");
endmodule

// file: verification/timer16_wave_tb_top.sv
// Purpose: self-checking bench for the timer's modes, compare pins and registers
// Assumes: apb master tasks, timer enable held low until the pulse runs and high from then on
// Notes: pulse duty is judged by high cycles at the pad over one period
`timescale 1ns/100ps
`include "timer16_map.vh"
module timer16_wave_tb_top;
   typedef struct packed {logic [11:0] a; logic [31:0] wd; logic [31:0] rx; logic e;} reg_row_t;
   typedef struct packed {logic [7:0] ca; logic [7:0] cb; logic [15:0] m; logic [15:0] per;
      logic [15:0] hi;} pwm_row_t;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg tick_en = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000;
   reg port_a = 1'b1;
   reg port_b = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, compare_pin_a, compare_pin_b, pin_drive_a, pin_drive_b;
   wire wrap_flag, match_flag_a, match_flag_b, pad_a, pad_b;
   integer failures = 0;
   integer compares = 0;
   integer i, hi;
   reg [31:0] rd_v;
   reg [31:0] hold_v;
   reg err_v;
   reg_row_t rows [0:7];
   pwm_row_t pw [0:4];
   always #5 mclk = ~mclk;
   timer16_wave uut (.mclk(mclk), .reset(reset), .tick_en(tick_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compare_pin_a(compare_pin_a),
      .compare_pin_b(compare_pin_b), .pin_drive_a(pin_drive_a), .pin_drive_b(pin_drive_b),
      .wrap_flag(wrap_flag), .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));
   port_pin_model pa (.compare_pin(compare_pin_a), .pin_drive(pin_drive_a),
      .port_out(port_a), .dir_out(1'b1), .pad(pad_a));
   port_pin_model pb (.compare_pin(compare_pin_b), .pin_drive(pin_drive_b),
      .port_out(port_b), .dir_out(1'b1), .pad(pad_b));
   // ==========================================================
   // reporting and bus tasks
   task final_report;
   begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   task check(input [31:0] got, input [31:0] exp, input integer tol);
   begin
      compares = compares + 1;
      if (got !== exp && (tol == 0 || got > exp + tol || got + tol < exp))
      begin
         failures = failures + 1;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task chk1(input b, input e);
      check({31'h0, b}, {31'h0, e}, 0);
   endtask
   // entered just after a rising edge; one idle cycle follows each transfer
   task apb(input [11:0] a, input [31:0] d, input w);
      integer n;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         failures = failures + 1;
         final_report;
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(a, d, 1'b1);
   endtask
   task rdc(input [11:0] a, input [31:0] exp);
   begin
      apb(a, 32'h00000000, 1'b0);
      check(rd_v, exp, 0);
   end
   endtask
   task measure(input [15:0] per, output integer n);
      integer k;
   begin
      n = 0;
      for (k = 0; k < per; k = k + 1)
      begin
         @(posedge mclk);
         if (pad_a === 1'b1)
            n = n + 1;
      end
   end
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      rows[0] = '{`OFF_CTRL_A, 32'h000000FF, 32'h000000F3, 1'b0};
      rows[1] = '{`OFF_CTRL_B, 32'h000000FF, 32'h00000019, 1'b0};
      rows[2] = '{`OFF_COUNT, 32'h00001234, 32'h00001234, 1'b0};
      rows[3] = '{`OFF_MATCH_A, 32'h00000456, 32'h00000456, 1'b0};
      rows[4] = '{`OFF_MATCH_B, 32'h000000AB, 32'h000000AB, 1'b0};
      rows[5] = '{`OFF_CAPTURE, 32'h00000321, 32'h00000321, 1'b0};
      rows[6] = '{12'h01C, 32'h0000FFFF, 32'h00000000, 1'b1};
      rows[7] = '{12'h020, 32'h0000FFFF, 32'h00000000, 1'b1};
      pw[0] = '{8'h81, 8'h01, 16'h0040, 16'd510, 16'd128};
      pw[1] = '{8'hC2, 8'h01, 16'h0040, 16'd1022, 16'd894};
      pw[2] = '{8'h83, 8'h01, 16'h0100, 16'd2046, 16'd512};
      pw[3] = '{8'h81, 8'h09, 16'h0040, 16'd256, 16'd65};
      pw[4] = '{8'h81, 8'h09, 16'h00FF, 16'd256, 16'd256};
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk1(pin_drive_a, 1'b0);
      chk1(pad_a, port_a);
      rdc(`OFF_CTRL_A, 32'h00000000);
      rdc(`OFF_CTRL_B, 32'h00000000);
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(rows[i].a, rows[i].wd);
         chk1(err_v, rows[i].e);
         rdc(rows[i].a, rows[i].rx);
         chk1(err_v, rows[i].e);
      end
      chk1(pin_drive_a, 1'b1);
      // forced compares with the timer stopped in plain modes, then one dropped in mode 1; each
      // strobe that is taken acts with the action bits held before its own write lands
      wr(`OFF_CTRL_B, 32'h00000000);
      wr(`OFF_CTRL_A, 32'h000000C0);
      wr(`OFF_CTRL_A, 32'h00000088);
      chk1(compare_pin_a, 1'b1);
      chk1(match_flag_a, 1'b0);
      wr(`OFF_CTRL_A, 32'h00000078);
      chk1(compare_pin_a, 1'b0);
      wr(`OFF_CTRL_A, 32'h0000003C);
      chk1(compare_pin_a, 1'b1);
      chk1(compare_pin_b, 1'b1);
      chk1(pad_a, port_a);
      wr(`OFF_CTRL_B, 32'h00000008);
      wr(`OFF_COUNT, 32'h00000005);
      wr(`OFF_MATCH_A, 32'h00000100);
      wr(`OFF_CTRL_A, 32'h00000088);
      wr(`OFF_CTRL_A, 32'h00000088);
      chk1(compare_pin_a, 1'b0);
      rdc(`OFF_COUNT, 32'h00000005);
      chk1(match_flag_a, 1'b0);
      wr(`OFF_CTRL_B, 32'h00000000);
      wr(`OFF_CTRL_A, 32'h000000C1);
      wr(`OFF_CTRL_A, 32'h000000C9);
      chk1(compare_pin_a, 1'b0);
      rdc(`OFF_CTRL_A, 32'h000000C1);
      // pulse runs: duty measured at the pad over one full period
      tick_en <= 1'b1;
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(`OFF_CTRL_B, 32'h00000000);
         wr(`OFF_COUNT, 32'h00000000);
         wr(`OFF_MATCH_A, {16'h0000, pw[i].m});
         wr(`OFF_CTRL_A, {24'h000000, pw[i].ca});
         wr(`OFF_CTRL_B, {24'h000000, pw[i].cb});
         repeat (pw[i].per) @(posedge mclk);
         wr(`OFF_STATUS, 32'h00000007);
         measure(pw[i].per, hi);
         check(hi, {16'h0000, pw[i].hi}, 3);
         chk1(wrap_flag, 1'b1);
         chk1(match_flag_a, 1'b1);
         chk1(match_flag_b, 1'b1);
      end
      wr(`OFF_CTRL_B, 32'h00000019);
      wr(`OFF_CTRL_A, 32'h000000C1);
      apb(`OFF_COUNT, 32'h00000000, 1'b0);
      hold_v = rd_v;
      rdc(`OFF_COUNT, hold_v);
      chk1(pin_drive_a, 1'b0);
      chk1(pin_drive_b, 1'b0);
      wr(`OFF_CTRL_B, 32'h00000011);
      wr(`OFF_CTRL_A, 32'h00000051);
      repeat (4) @(posedge mclk);
      chk1(pin_drive_a, 1'b1);
      chk1(pin_drive_b, 1'b0);
      chk1(pad_b, port_b);
      final_report;
   end
   initial
   begin
      repeat (60000) @(posedge mclk);
      failures = failures + 1;
      final_report;
   end
endmodule
bind timer16_wave timer16_wave_properties chk (.mclk(mclk), .reset(reset), .tick_en(tick_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_pin_a(compare_pin_a),
   .compare_pin_b(compare_pin_b), .pin_drive_a(pin_drive_a), .pin_drive_b(pin_drive_b),
   .wrap_flag(wrap_flag), .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));
